// ---- trig_cfg.svh ----
// Purpose: Offsets, encodings and timing counts of the trigger detector.
// Assumes: 100 MHz reference clock.
// Notes:   Times are kept as printed; cycle counts are derived here.
`ifndef TRIG_CFG_SVH
`define TRIG_CFG_SVH
`define CLK_PS 10000
`define PS_PER_S 64'd1000000000000
`define GLITCH_MIN_PS 150
`define LIM_MIN_CYC ((`GLITCH_MIN_PS + `CLK_PS - 1) / `CLK_PS)
`define TMO_MIN_PS 300
`define TMO_MIN_CYC ((`TMO_MIN_PS + `CLK_PS - 1) / `CLK_PS)
`define HOLD_MIN_NS 250
`define HOLD_MIN_CYC ((`HOLD_MIN_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define HOLD_MAX_S 12
`define HOLD_MAX_CYC (`HOLD_MAX_S * `PS_PER_S / `CLK_PS)
`define DLY_MIN_PS 3200
`define DLY_MIN_CYC ((`DLY_MIN_PS + `CLK_PS - 1) / `CLK_PS)
`define DLY_MAX_S 3000000
`define DLY_MAX_CYC (`DLY_MAX_S * `PS_PER_S / `CLK_PS)
`define EVT_MIN 31'h1
`define EVT_MAX 2000000000
`define AUTO_CYC 10000000
`define PLAIN_MAX_MBD 13'd1250
`define NRZ_MAX_MBD 13'd6250
// Decoder event bits: 0-6 I2C start, rstart, stop, nack, addr, data, addr+data;
// 7-8 SPI select, data; 9-12 UART start, end, data, parity; 13-19 CAN sof,
// type, id, data, eof, nack, stuff; 20 serial pattern match.
`define EV_W 21
`define EV_SERPAT 20
`define EV_MATCH 21'h01C970
`define Q_HIGH 2'h1
`define Q_LOW 2'h2
`define STATE_CLK 3
`define STATE_MASK 40'hFFFFFFFF3F
`define CHAN_RST 25'h0
`define LFSR_RST 8'h01
`endif

// ---- trig_pkg.sv ----
// Purpose: Types shared by the trigger detector and its users.
// Assumes: Constants come from trig_cfg.svh.
// Notes:   Channel index 0-3 analog, 4-19 logic, 20 auxiliary.
package trig_pkg;
    typedef enum logic [1:0] {M_AUTO = 2'h0, M_NORMAL = 2'h1, M_SINGLE = 2'h2} mode_t;
    typedef enum logic [3:0] {
        K_EDGE = 4'h0, K_GLITCH = 4'h1, K_WIDTH = 4'h2, K_TMO = 4'h3,
        K_RUNT = 4'h4, K_WIN = 4'h5, K_TRAN = 4'h6, K_SETHLD = 4'h7,
        K_PAT = 4'h8, K_STATE = 4'h9, K_PBUS = 4'hA, K_SBUS = 4'hB,
        K_SERPAT = 4'hC
    } kind_t;
    typedef enum logic [1:0] {S_MAIN = 2'h0, S_EVT = 2'h1, S_TIME = 2'h2, S_SCAN = 2'h3} seq_t;
    typedef enum logic [1:0] {O_AND = 2'h0, O_OR = 2'h1, O_NAND = 2'h2, O_NOR = 2'h3} op_t;
    typedef enum logic [1:0] {P_POS = 2'h0, P_NEG = 2'h1, P_ANY = 2'h2} pol_t;
    typedef enum logic [1:0] {SC_SEQ = 2'h0, SC_RAND = 2'h1, SC_ALT = 2'h2} scan_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ARM = 2'h1, ST_B = 2'h2, ST_HOLD = 2'h3} st_t;
    typedef struct packed {
        logic [3:0]  hi;
        logic [3:0]  lo;
        logic [15:0] dig;
        logic        aux;
    } chan_t;
    typedef struct packed {
        logic [20:0] evt;
        logic [31:0] word;
    } proto_t;
    typedef struct packed {
        kind_t       kind;
        mode_t       mode;
        seq_t        seq;
        scan_t       scan;
        op_t         op;
        pol_t        pol;
        logic        neg;
        logic        inv;
        logic        tq;
        logic        qen;
        logic        enc;
        logic [4:0]  src;
        logic [4:0]  dsrc;
        logic [4:0]  bsrc;
        logic        bneg;
        logic [31:0] lim_lo;
        logic [31:0] lim_hi;
        logic [39:0] pat;
        logic [39:0] qual;
        logic [30:0] nevt;
        logic [63:0] dly;
        logic [30:0] hold;
        logic [7:0]  scan_len;
        logic [20:0] evt_mask;
        logic [31:0] val;
        logic [31:0] val_mask;
        logic [12:0] baud;
    } cfg_t;
endpackage

// ---- trigger_event_detector.sv ----
// Purpose: Trigger event detection and A-to-B sequencing.
// Assumes: Comparator levels arrive from pins; decoder events on this clock.
// Notes:   Sub-cycle limits collapse to one clock cycle.
// Summary of operation
// - Edge trigger on chosen rising or falling transition of any channel or aux.
// - Glitch trigger fires on or rejects pulses narrower than limit, any polarity.
// - Pattern trigger fires when condition goes false or stays true long enough.
// - Pattern combines four analog and sixteen logic inputs by AND, OR, NAND, NOR.
// - State trigger samples channels one to three and logic on channel four edge.
// - Timeout fires when signal stays high, low or either longer than limit.
// - Width trigger fires when pulse width is inside or outside two limits.
// - Runt fires when pulse crosses first threshold but not second before returning.
// - Window fires on entering or leaving band between two thresholds.
// - Transition fires when edge time through band is faster or slower than limit.
// - Setup/hold fires on data change too near a clock edge on another channel.
// - After A, the trigger waits for a counted number of B events.
// - After A, the trigger waits a programmed time before the next B event.
// - Bus trigger fires when grouped parallel or serial bus shows programmed value.
// - I2C events: start, restart, stop, missing ack, address, data, both.
// - SPI fires on slave select or data match.
// - Serial port fires on start bit, end of packet, data match, parity error.
// - CAN fires on frame start, type, identifier, data, end, missing ack, stuffing.
// - Serial pattern up to 6.25 Gbaud; above 1.25 Gbaud needs 8b/10b.
// - Scan steps B count sequentially, randomly, or alternates between two B events.
// - After each trigger, triggers are ignored for a holdoff of 250 ns to 12 s.
// - Auto, normal and single modes; single arms for one trigger only.
`include "trig_cfg.svh"
module trigger_event_detector #(
    parameter longint unsigned HOLD_MAX = `HOLD_MAX_CYC,
    parameter longint unsigned DLY_MAX  = `DLY_MAX_CYC,
    parameter logic [30:0]     EVT_MAX  = 31'(`EVT_MAX),
    parameter logic [31:0]     AUTO_CYC = 32'(`AUTO_CYC)
) (
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst,
    input  wire trig_pkg::chan_t  i_chan,
    input  wire trig_pkg::proto_t i_proto,
    input  wire trig_pkg::cfg_t   i_cfg,
    input  wire logic            i_arm,
    output logic                 o_trig,
    output logic                 o_auto,
    output logic                 o_armed,
    output logic                 o_wait_b
);
    import trig_pkg::*;

    chan_t       s1;
    chan_t       s2;
    logic [20:0] lv;
    logic [20:0] lvp;
    logic [3:0]  lop;
    logic        sel;
    logic        selp;
    logic        a;
    logic        b;
    logic        ap;
    logic        bp;
    logic        rp;
    logic        rn;
    logic        d;
    logic        dp;
    logic        cond;
    logic        condp;
    logic [31:0] wcnt;
    logic [31:0] bcnt;
    logic [31:0] dcnt;
    logic [31:0] ccnt;
    logic [31:0] pcnt;
    logic [31:0] lim_e;
    logic        qok;
    logic        timeok;
    logic        aevt;
    logic        bevt;
    logic        fire;
    logic        force_t;
    logic        bfire;
    st_t         st;
    logic [31:0] acnt;
    logic [30:0] ecnt;
    logic [63:0] tcnt;
    logic [30:0] hcnt;
    logic [63:0] hold_e;
    logic [63:0] dly_e;
    logic [30:0] nevt_e;
    logic [30:0] tgt;
    logic [7:0]  pos;
    logic [7:0]  lfsr;
    logic [20:0] em;
    logic        wm;

    function automatic logic [31:0] inc(input logic [31:0] c);
        return (&c) ? c : c + 32'h1;
    endfunction

    function automatic logic polok(input pol_t p, input logic l);
        return (p == P_ANY) || ((p == P_POS) == l);
    endfunction

    function automatic logic pat(input logic [39:0] q, input logic [19:0] v, input op_t op);
        logic any;
        logic all;
        any = 1'b0;
        all = 1'b1;
        for (int i = 0; i < 20; i++) begin
            if (q[2*i+:2] == `Q_HIGH) begin
                any = any | v[i];
                all = all & v[i];
            end else if (q[2*i+:2] == `Q_LOW) begin
                any = any | !v[i];
                all = all & !v[i];
            end
        end
        case (op)
            O_AND:   return all;
            O_OR:    return any;
            O_NAND:  return !all;
            default: return !any;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and history.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1 <= `CHAN_RST;
            s2 <= `CHAN_RST;
        end else begin
            s1 <= i_chan;
            s2 <= s1;
        end
    end

    assign lv   = {s2.aux, s2.dig, s2.hi};
    assign sel  = lv[i_cfg.src];
    assign selp = lvp[i_cfg.src];
    assign a    = s2.lo[i_cfg.src[1:0]];
    assign b    = s2.hi[i_cfg.src[1:0]];
    assign ap   = lop[i_cfg.src[1:0]];
    assign bp   = lvp[i_cfg.src[1:0]];
    assign d    = lv[i_cfg.dsrc];
    assign dp   = lvp[i_cfg.dsrc];
    assign cond = pat(i_cfg.pat, lv[19:0], i_cfg.op);
    assign qok  = !i_cfg.qen || pat(i_cfg.qual, lv[19:0], O_AND);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lvp   <= '0;
            lop   <= '0;
            condp <= 1'b0;
            rp    <= 1'b0;
            rn    <= 1'b0;
        end else begin
            lvp   <= lv;
            lop   <= s2.lo;
            condp <= cond;
            if (b || !a) rp <= 1'b0;
            else if (!ap) rp <= 1'b1;
            if (!a || b) rn <= !a ? 1'b0 : rn;
            else if (bp) rn <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wcnt <= '0;
            bcnt <= '0;
            dcnt <= '0;
            ccnt <= '0;
            pcnt <= '0;
        end else begin
            wcnt <= (sel != selp) ? 32'h1 : inc(wcnt);
            bcnt <= ({a, b} != {ap, bp}) ? 32'h1 : inc(bcnt);
            dcnt <= (d != dp) ? 32'h1 : inc(dcnt);
            ccnt <= (sel != selp && sel == !i_cfg.neg) ? 32'h1 : inc(ccnt);
            pcnt <= cond ? inc(pcnt) : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // A event selection.
    assign lim_e  = (i_cfg.kind == K_TMO) ?
                    ((i_cfg.lim_lo < `TMO_MIN_CYC) ? 32'(`TMO_MIN_CYC) : i_cfg.lim_lo) :
                    ((i_cfg.lim_lo < `LIM_MIN_CYC) ? 32'(`LIM_MIN_CYC) : i_cfg.lim_lo);
    assign timeok = !i_cfg.tq || bcnt >= lim_e;
    assign em     = i_proto.evt & i_cfg.evt_mask;
    assign wm     = ((i_proto.word ^ i_cfg.val) & i_cfg.val_mask) == 32'h0;

    always_comb begin
        case (i_cfg.kind)
            // Edge on any channel or aux.
            K_EDGE:   aevt = sel != selp && sel == !i_cfg.neg;
            K_GLITCH: aevt = qok && sel != selp && polok(i_cfg.pol, selp) && ((wcnt < lim_e) ^ i_cfg.inv);
            K_WIDTH:  aevt = qok && sel != selp && polok(i_cfg.pol, selp) &&
                             ((wcnt >= lim_e && wcnt <= i_cfg.lim_hi) ^ i_cfg.inv);
            K_TMO:    aevt = qok && sel == selp && polok(i_cfg.pol, sel) && wcnt == lim_e;
            K_RUNT:   aevt = qok && timeok && ((!a && ap && rp && i_cfg.pol != P_NEG) ||
                             (b && !bp && rn && i_cfg.pol != P_POS));
            K_WIN:    aevt = qok && timeok && (i_cfg.inv ? (ap && !bp && !(a && !b)) :
                             (a && !b && !(ap && !bp)));
            K_TRAN:   aevt = qok && ((b && !bp && ap && polok(i_cfg.pol, 1'b1)) ||
                             (!a && ap && !bp && polok(i_cfg.pol, 1'b0))) && ((bcnt < lim_e) ^ i_cfg.inv);
            K_SETHLD: aevt = qok && ((sel != selp && sel == !i_cfg.neg && dcnt < i_cfg.lim_lo) ||
                             (d != dp && ccnt < i_cfg.lim_hi));
            // Pattern false or true long enough.
            K_PAT:    aevt = i_cfg.inv ? (cond && pcnt == lim_e) : (condp && !cond);
            // Pattern sampled on channel four edge.
            K_STATE:  aevt = lv[`STATE_CLK] != lvp[`STATE_CLK] && lv[`STATE_CLK] == !i_cfg.neg &&
                             pat(i_cfg.pat & `STATE_MASK, lv[19:0], i_cfg.op);
            K_PBUS:   aevt = lv != lvp && ((({11'h0, lv} ^ i_cfg.val) & i_cfg.val_mask) == 32'h0);
            K_SBUS:   aevt = |(em & ~`EV_MATCH) || (|(em & `EV_MATCH) && wm);
            K_SERPAT: aevt = i_proto.evt[`EV_SERPAT] && i_cfg.baud <= `NRZ_MAX_MBD &&
                             (i_cfg.baud <= `PLAIN_MAX_MBD || i_cfg.enc);
            default:  aevt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    assign bevt   = lv[i_cfg.bsrc] != lvp[i_cfg.bsrc] && lv[i_cfg.bsrc] == !i_cfg.bneg;
    assign nevt_e = (i_cfg.nevt < `EVT_MIN) ? `EVT_MIN : ((i_cfg.nevt > EVT_MAX) ? EVT_MAX : i_cfg.nevt);
    assign tgt    = (i_cfg.seq == S_SCAN) ? {23'h0, pos} + 31'h1 : nevt_e;
    assign dly_e  = (i_cfg.dly < `DLY_MIN_CYC) ? 64'(`DLY_MIN_CYC) : ((i_cfg.dly > DLY_MAX) ? DLY_MAX : i_cfg.dly);
    assign hold_e = ({33'h0, i_cfg.hold} < `HOLD_MIN_CYC) ? 64'(`HOLD_MIN_CYC) :
                    (({33'h0, i_cfg.hold} > HOLD_MAX) ? HOLD_MAX : {33'h0, i_cfg.hold});
    assign bfire  = bevt && ((i_cfg.seq == S_TIME) ? tcnt >= dly_e : ecnt + 31'h1 == tgt);
    assign force_t = i_cfg.mode == M_AUTO && (st == ST_ARM || st == ST_B) && acnt >= AUTO_CYC - 32'h1;
    assign fire   = force_t || (st == ST_ARM && aevt && i_cfg.seq == S_MAIN) || (st == ST_B && bfire);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= ST_ARM;
        end else begin
            case (st)
                ST_IDLE: if (i_arm) st <= ST_ARM;
                ST_ARM:  if (fire) st <= ST_HOLD;
                         else if (aevt && i_cfg.seq != S_MAIN) st <= ST_B;
                ST_B:    if (fire) st <= ST_HOLD;
                ST_HOLD: if ({33'h0, hcnt} >= hold_e - 64'h1) st <= (i_cfg.mode == M_SINGLE) ? ST_IDLE : ST_ARM;
                default: st <= ST_ARM;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            acnt <= '0;
            ecnt <= '0;
            tcnt <= '0;
            hcnt <= '0;
        end else begin
            acnt <= (st == ST_ARM || st == ST_B) && !fire ? acnt + 32'h1 : 32'h0;
            ecnt <= (st == ST_B) ? ecnt + 31'(bevt) : 31'h0;
            tcnt <= (st == ST_B) ? tcnt + 64'h1 : 64'h1;
            hcnt <= (st == ST_HOLD) ? hcnt + 31'h1 : 31'h0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pos  <= '0;
            lfsr <= `LFSR_RST;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            if (fire && !force_t && i_cfg.seq == S_SCAN) begin
                case (i_cfg.scan)
                    SC_SEQ:  pos <= (pos + 8'h1 >= i_cfg.scan_len) ? 8'h0 : pos + 8'h1;
                    SC_RAND: pos <= (i_cfg.scan_len == 8'h0) ? 8'h0 : lfsr % i_cfg.scan_len;
                    default: pos <= {7'h0, ~pos[0]};
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_trig   <= 1'b0;
            o_auto   <= 1'b0;
            o_armed  <= 1'b0;
            o_wait_b <= 1'b0;
        end else begin
            o_trig   <= fire;
            o_auto   <= force_t;
            o_armed  <= ((st == ST_ARM || st == ST_B) && !fire) || (st == ST_IDLE && i_arm) ||
                        (st == ST_HOLD && {33'h0, hcnt} >= hold_e - 64'h1 && i_cfg.mode != M_SINGLE);
            o_wait_b <= st == ST_B;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_armed_a;
        st == ST_ARM && i_cfg.seq == S_MAIN;
    endsequence

    chk_strobe_width: assert property (o_trig |=> !o_trig)
        else $error("trigger strobe longer than one cycle");
    chk_holdoff_gap: assert property (o_trig |=> (!o_trig) [*8])
        else $error("trigger inside holdoff");
    chk_single_disarm: assert property (fire && i_cfg.mode == M_SINGLE |=> ##1 !o_armed)
        else $error("single mode stayed armed");
    chk_edge_fire: assert property (s_armed_a and (i_cfg.kind == K_EDGE && !i_cfg.neg && sel && !selp)
        |=> o_trig)
        else $error("edge not triggered");
    chk_glitch_pos: assert property (i_cfg.kind == K_GLITCH && i_cfg.pol == P_POS && !i_cfg.inv && !i_cfg.qen
        && selp && !sel && wcnt < lim_e |-> aevt)
        else $error("glitch missed");
    chk_timeout_held: assert property (aevt && i_cfg.kind == K_TMO && i_cfg.pol == P_POS && i_cfg.lim_lo == 32'h4
        |-> sel && $past(sel) && $past(sel, 2) && $past(sel, 3))
        else $error("timeout without held level");
    chk_pattern_false: assert property (s_armed_a and (i_cfg.kind == K_PAT && !i_cfg.inv && condp && !cond)
        |=> o_trig)
        else $error("pattern false not triggered");
    chk_event_count: assert property (st == ST_B && i_cfg.seq == S_EVT && i_cfg.nevt == 31'h1 && bevt
        |=> o_trig)
        else $error("first B event not triggered");
    chk_time_delay: assert property (o_trig && !o_auto && $past(st) == ST_B && i_cfg.seq == S_TIME
        |-> $past(tcnt) >= $past(dly_e))
        else $error("B trigger before delay");
    chk_serial_rate: assert property (aevt && i_cfg.kind == K_SERPAT
        |-> i_cfg.enc || i_cfg.baud <= `PLAIN_MAX_MBD)
        else $error("fast serial match without 8b10b");
endmodule

// ---- sig_source.sv ----
// Purpose: Signal source standing in for the probed circuit and decoders.
// Assumes: Levels change 1 ns after a rising clock edge.
// Notes:   Lower comparators follow the upper ones on analog inputs.
module sig_source (
    input  wire logic       i_ref_clk,
    output trig_pkg::chan_t  o_chan,
    output trig_pkg::proto_t o_proto
);
    timeunit 1ns;
    timeprecision 100ps;
    import trig_pkg::*;
    logic [20:0] lv = 21'h000000;

    ////////////////////////////////////////////////////////////////////////
    assign o_chan = {lv[3:0], lv[3:0], lv[19:4], lv[20]};
    initial o_proto = '0;

    ////////////////////////////////////////////////////////////////////////
    // Sets one level index after the next clock edge.
    task automatic set_lv(input int idx, input logic val);
        @(posedge i_ref_clk);
        #1 lv[idx] = val;
    endtask

    // Drives a pulse of a given width in cycles, then idles for gap cycles.
    task automatic pulse(input int idx, input logic val, input int width, input int gap);
        set_lv(idx, val);
        repeat (width - 1) @(posedge i_ref_clk);
        set_lv(idx, ~val);
        repeat (gap) @(posedge i_ref_clk);
        #1;
    endtask

    // Sends a one-cycle decoder event; the word is inverted once released.
    task automatic send_evt(input int bitn, input logic [31:0] word);
        @(posedge i_ref_clk);
        #1 o_proto = {21'h000001 << bitn, word};
        @(posedge i_ref_clk);
        #1 o_proto = {21'h000000, ~word};
        repeat (40) @(posedge i_ref_clk);
        #1;
    endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the trigger event detector.
// Assumes: Short holdoff, delay and auto counts set by parameters.
// Notes:   Each scenario starts from a fresh reset.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import trig_pkg::*;
    localparam logic [12:0] BAUDS [4] = '{13'h04E2, 13'h04E3, 13'h186A, 13'h186B};
    logic   i_ref_clk = 1'b0;
    logic   i_rst     = 1'b1;
    logic   i_arm     = 1'b0;
    cfg_t   cfg       = '0;
    chan_t  chan;
    proto_t proto;
    logic   o_trig;
    logic   o_auto;
    logic   o_armed;
    logic   o_wait_b;
    int     n_fail    = 0;
    int     checked   = 0;
    int     ntrig     = 0;
    int     nauto     = 0;
    int     lat;

    ////////////////////////////////////////////////////////////////////////
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        if (o_trig === 1'b1) ntrig++;
        if (o_auto === 1'b1) nauto++;
    end

    sig_source src_i (.i_ref_clk(i_ref_clk), .o_chan(chan), .o_proto(proto));
    trigger_event_detector #(.HOLD_MAX(64'h64), .DLY_MAX(64'h3E8), .AUTO_CYC(32'hC8)) trigger_event_detector_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_chan(chan), .i_proto(proto), .i_cfg(cfg),
        .i_arm(i_arm), .o_trig(o_trig), .o_auto(o_auto), .o_armed(o_armed), .o_wait_b(o_wait_b));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic cfg_t base(input kind_t k, input mode_t m, input logic [4:0] s);
        base = '0;
        base.kind = k;
        base.mode = m;
        base.src = s;
    endfunction

    task automatic start(input cfg_t c, input logic [20:0] idle);
        cfg = c;
        i_rst = 1'b1;
        src_i.lv = idle;
        repeat (5) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        ntrig = 0;
        nauto = 0;
        repeat (4) @(posedge i_ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cfg_t c;
        start(base(K_EDGE, M_NORMAL, 5'h00), 21'h000000);
        src_i.set_lv(0, 1'b1);
        lat = 0;
        while (o_trig !== 1'b1 && lat < 20) begin
            @(posedge i_ref_clk);
            #1 lat++;
        end
        check("edge latency", lat, 3);
        check("armed in holdoff", o_armed, 1'b0);
        @(posedge i_ref_clk);
        #1 check("strobe width", o_trig, 1'b0);
        src_i.pulse(0, 1'b0, 2, 30);
        check("held off", ntrig, 1);
        check("rearmed", o_armed, 1'b1);
        src_i.pulse(0, 1'b0, 2, 10);
        check("edge after rearm", ntrig, 2);
        c = base(K_EDGE, M_NORMAL, 5'h14);
        c.neg = 1'b1;
        start(c, 21'h100000);
        src_i.pulse(20, 1'b0, 40, 10);
        check("aux falling edge", ntrig, 1);
        // Pulses of 2, 5 and 9 cycles against limits 4 to 6.
        for (int k = 0; k < 4; k++) begin
            c = base(k[1] ? K_WIDTH : K_GLITCH, M_NORMAL, 5'h05);
            c.inv = k[0];
            c.lim_lo = 32'h4;
            c.lim_hi = 32'h6;
            start(c, 21'h000000);
            src_i.pulse(5, 1'b1, 2, 40);
            src_i.pulse(5, 1'b1, 5, 40);
            src_i.pulse(5, 1'b1, 9, 40);
            check("pulse width class", ntrig, 32'(1 + k[0]));
        end
        c = base(K_TMO, M_NORMAL, 5'h06);
        c.lim_lo = 32'hA;
        start(c, 21'h000000);
        src_i.pulse(6, 1'b1, 5, 30);
        check("short high", ntrig, 0);
        src_i.pulse(6, 1'b1, 20, 30);
        check("long high", ntrig, 1);
        c = base(K_PAT, M_NORMAL, 5'h00);
        c.pat = 40'h0000000201;
        start(c, 21'h000000);
        src_i.pulse(0, 1'b1, 6, 40);
        check("pattern goes false", ntrig, 1);
        src_i.set_lv(4, 1'b1);
        src_i.pulse(0, 1'b1, 6, 40);
        check("pattern never true", ntrig, 1);
        c.inv = 1'b1;
        c.lim_lo = 32'h5;
        start(c, 21'h000000);
        src_i.pulse(0, 1'b1, 3, 40);
        src_i.pulse(0, 1'b1, 8, 40);
        check("pattern true for time", ntrig, 1);
        c = base(K_EDGE, M_NORMAL, 5'h00);
        c.seq = S_EVT;
        c.bsrc = 5'h06;
        c.nevt = 31'h3;
        start(c, 21'h000000);
        src_i.pulse(0, 1'b1, 4, 6);
        check("waiting for B", o_wait_b, 1'b1);
        for (int n = 1; n <= 3; n++) begin
            src_i.pulse(6, 1'b1, 2, 6);
            check("B event count", ntrig, 32'(n == 3));
        end
        c.seq = S_TIME;
        c.dly = 64'h14;
        start(c, 21'h000000);
        src_i.pulse(0, 1'b1, 4, 2);
        src_i.pulse(6, 1'b1, 2, 30);
        src_i.pulse(6, 1'b1, 2, 10);
        check("B after delay", ntrig, 1);
        start(base(K_EDGE, M_SINGLE, 5'h00), 21'h000000);
        src_i.pulse(0, 1'b1, 2, 40);
        src_i.pulse(0, 1'b1, 2, 40);
        check("single shot", ntrig, 1);
        check("stopped", o_armed, 1'b0);
        @(posedge i_ref_clk);
        #1 i_arm = 1'b1;
        @(posedge i_ref_clk);
        #1 i_arm = 1'b0;
        src_i.pulse(0, 1'b1, 2, 40);
        check("rearmed single", ntrig, 2);
        start(base(K_EDGE, M_AUTO, 5'h00), 21'h000000);
        repeat (300) @(posedge i_ref_clk);
        check("auto forced", nauto, 1);
        check("auto strobe", ntrig, 1);
        c = base(K_SBUS, M_NORMAL, 5'h00);
        c.evt_mask = 21'h000210;
        c.val = 32'h0000005A;
        c.val_mask = 32'hFFFFFFFF;
        start(c, 21'h000000);
        src_i.send_evt(9, 32'h0);
        src_i.send_evt(8, 32'h5A);
        src_i.send_evt(4, 32'h5B);
        check("masked events", ntrig, 1);
        src_i.send_evt(4, 32'h5A);
        check("address match", ntrig, 2);
        for (int i = 0; i < 4; i++) begin
            c = base(K_SERPAT, M_NORMAL, 5'h00);
            c.baud = BAUDS[i];
            c.enc = i[1];
            start(c, 21'h000000);
            src_i.send_evt(20, 32'h0);
            check("serial rate", ntrig, 32'(!i[0]));
        end
        end_sim();
    end

    initial begin
        #100us;
        n_fail++;
        end_sim();
    end
endmodule
